// *** etsr_pkg.sv ***
// Constants and types for the event timestamp readout block
//
// Operation
// - With an extended status word present, the first data read returns it.
// - The extended word exists only when the multi-capture flag is set.
// - Each timestamp is read as four 16-bit words from one data register.
// - Word order is ns[15:0], ns[29:16], sec[15:0], sec[31:16].
// - The top two bits of the upper nanoseconds word always read zero.
// - The data register is valid only while the status shows an entry.
// - A status read moves the readout to the next entry, dropping the old.
// - Unit n reports seen at bit 2n and edge direction at bit 2n+1.
// - A direction bit reads 0 for a falling and 1 for a rising edge.
// - A seen bit means the unit fired at the timestamp of the same entry.
// - The data register at index 0x1F is read-only, 16 bits per read.
// - The changed word count is new low words minus one, 00 up to 11.
// - An all-zero status means no timestamp is available.
// - The multi-capture flag is set for two or more units, else clear.
package etsr_pkg;
	localparam int UNITS       = 8;
	localparam int NS_W        = 30;
	localparam int SEC_W       = 32;
	localparam int WORD_W      = 16;
	localparam int QUEUE_DEPTH = 8;
	localparam int ADDR_W      = 10;
	localparam int IRQ_W       = 2;

	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_EVENT_STATUS = 8'h1e;
	localparam logic [7:0] IDX_EVENT_DATA   = 8'h1f;
	localparam logic [7:0] IDX_IRQ_STATUS   = 8'h20;
	localparam logic [7:0] IDX_IRQ_ENABLE   = 8'h21;
	localparam logic [7:0] IDX_IRQ_CLEAR    = 8'h22;
	localparam logic [ADDR_W-1:0] ADDR_EVENT_STATUS = {IDX_EVENT_STATUS, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_EVENT_DATA   = {IDX_EVENT_DATA, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS   = {IDX_IRQ_STATUS, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE   = {IDX_IRQ_ENABLE, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR    = {IDX_IRQ_CLEAR, 2'h0};

	// Event status word field positions
	localparam int ST_DET    = 0;
	localparam int ST_MULTI  = 1;
	localparam int ST_NUM    = 2;
	localparam int ST_RF     = 5;
	localparam int ST_LEN    = 6;
	localparam int ST_MISSED = 8;

	// Interrupt bit positions and reset values
	localparam int IRQ_QUEUED  = 0;
	localparam int IRQ_DROPPED = 1;
	localparam logic [IRQ_W-1:0] IRQ_ENABLE_RESET = 2'h0;
	localparam logic [IRQ_W-1:0] IRQ_STATUS_RESET = 2'h0;
	localparam logic [2:0]       MISSED_MAX       = 3'h7;

	typedef enum logic [2:0] {
		WSEL_EXT,
		WSEL_NS_LO,
		WSEL_NS_HI,
		WSEL_SEC_LO,
		WSEL_SEC_HI
	} etsr_wsel_t;

	typedef struct packed {
		logic [UNITS-1:0] edge_up;
		logic [UNITS-1:0] seen;
		logic [SEC_W-1:0] sec;
		logic [NS_W-1:0]  ns;
	} etsr_capture_t;

	typedef struct packed {
		etsr_capture_t cap;
		logic [2:0]    missed;
		logic [1:0]    len;
	} etsr_entry_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              write;
	} etsr_req_t;
endpackage

// *** etsr_queue.sv ***
// Small dual-port memory holding queued capture entries
`timescale 1ns/1ps
module etsr_queue #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8,
	parameter int AW    = 3
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Write side
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	// Read side, data one cycle after the address
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule

// *** etsr_top.sv ***
// Event timestamp queue readout with AHB-Lite register slave
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module etsr_top #(
	parameter int DEPTH = etsr_pkg::QUEUE_DEPTH
) (
	// Clock and reset
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	// AHB-Lite slave
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic                        hreadyout,
	output logic                        hresp,
	output logic      [31:0]            hrdata,
	// Captures from the timestamp units
	input  wire logic                   cap_valid,
	input  wire etsr_pkg::etsr_capture_t cap_entry,
	output logic                        cap_ready,
	// Interrupt
	output logic                        irq
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int W  = etsr_pkg::WORD_W;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic multi_of(input logic [etsr_pkg::UNITS-1:0] s);
		multi_of = |(s & (s - 1'b1));
	endfunction

	function automatic logic [2:0] lowest_of(
		input logic [etsr_pkg::UNITS-1:0] s);
		logic [2:0] n;
		n = 3'h0;
		for (int i = etsr_pkg::UNITS - 1; i >= 0; i--) begin
			if (s[i]) begin
				n = i[2:0];
			end
		end
		lowest_of = n;
	endfunction

	// Count of changed low words minus one
	function automatic logic [1:0] len_of(input etsr_pkg::etsr_capture_t a,
		input etsr_pkg::etsr_capture_t b);
		logic [1:0] l;
		l = 2'h0;
		if (a.sec[31:16] != b.sec[31:16]) begin
			l = 2'h3;
		end else if (a.sec[15:0] != b.sec[15:0]) begin
			l = 2'h2;
		end else if (a.ns[29:16] != b.ns[29:16]) begin
			l = 2'h1;
		end
		len_of = l;
	endfunction

	function automatic logic [W-1:0] status_of(input etsr_pkg::etsr_entry_t e);
		logic [W-1:0] s;
		logic [2:0]   n;
		n = lowest_of(e.cap.seen);
		s = '0;
		s[etsr_pkg::ST_DET]          = 1'b1;
		s[etsr_pkg::ST_MULTI]        = multi_of(e.cap.seen);
		s[etsr_pkg::ST_NUM +: 3]     = n;
		s[etsr_pkg::ST_RF]           = e.cap.edge_up[n];
		s[etsr_pkg::ST_LEN +: 2]     = e.len;
		s[etsr_pkg::ST_MISSED +: 3]  = e.missed;
		status_of = s;
	endfunction

	// Extended word: seen at 2n, direction at 2n+1
	function automatic logic [W-1:0] ext_of(input etsr_pkg::etsr_capture_t c);
		logic [W-1:0] x;
		x = '0;
		for (int i = 0; i < etsr_pkg::UNITS; i++) begin
			x[2*i]   = c.seen[i];
			x[2*i+1] = c.edge_up[i];
		end
		ext_of = x;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [AW-1:0]           wr_ptr;
	logic [AW-1:0]           rd_ptr;
	logic [AW:0]             vis_fill;
	logic                    push_d1;
	logic [2:0]              missed;
	etsr_pkg::etsr_capture_t last_cap;
	etsr_pkg::etsr_entry_t   head;
	etsr_pkg::etsr_entry_t   cur;
	logic                    cur_valid;
	etsr_pkg::etsr_wsel_t    wsel;
	logic                    busy;
	etsr_pkg::etsr_req_t     req;
	logic [etsr_pkg::IRQ_W-1:0] irq_status;
	logic [etsr_pkg::IRQ_W-1:0] irq_enable;

	////////////////////////////////////////////////////////////////////////
	// Queue write side

	wire logic [AW:0] fill_all = vis_fill + {{AW{1'b0}}, push_d1};
	wire logic        full     = (fill_all == DEPTH[AW:0]);
	wire logic        push     = cap_valid & ~full;
	wire logic        drop     = cap_valid & full;
	wire logic        head_valid = (vis_fill != '0);

	wire etsr_pkg::etsr_entry_t new_entry = '{
		cap:    cap_entry,
		missed: missed,
		len:    len_of(cap_entry, last_cap)
	};

	assign cap_ready = ~full;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ptr   <= '0;
			push_d1  <= 1'b0;
			last_cap <= '0;
		end else begin
			push_d1 <= push;
			if (push) begin
				wr_ptr   <= wr_ptr + 1'b1;
				last_cap <= cap_entry;
			end
		end
	end

	// Drops while full are counted onto the next queued entry
	wire logic [2:0] next_missed = push ? 3'h0 :
		(drop && missed != etsr_pkg::MISSED_MAX) ? missed + 3'h1 : missed;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			missed <= 3'h0;
		end else begin
			missed <= next_missed;
		end
	end

	etsr_queue #(
		.WIDTH ($bits(etsr_pkg::etsr_entry_t)),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_queue (
		.clk     (hclk),
		.rst_n   (hresetn),
		.wr_en   (push),
		.wr_addr (wr_ptr),
		.wr_data (new_entry),
		.rd_addr (rd_ptr),
		.rd_data (head)
	);

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: one wait state on every transfer

	wire logic addr_take = hsel & htrans[1] & hready & ~busy;
	wire logic rd_act    = busy & ~req.write;
	wire logic wr_act    = busy & req.write;

	wire logic sel_status = (req.addr == etsr_pkg::ADDR_EVENT_STATUS);
	wire logic sel_data   = (req.addr == etsr_pkg::ADDR_EVENT_DATA);
	wire logic sel_istat  = (req.addr == etsr_pkg::ADDR_IRQ_STATUS);
	wire logic sel_ien    = (req.addr == etsr_pkg::ADDR_IRQ_ENABLE);
	wire logic sel_iclr   = (req.addr == etsr_pkg::ADDR_IRQ_CLEAR);

	wire logic status_rd = rd_act & sel_status;
	wire logic pop       = status_rd & head_valid;
	wire logic data_rd   = rd_act & sel_data & cur_valid;

	assign hreadyout = ~busy;
	assign hresp     = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy <= 1'b0;
			req  <= '0;
		end else begin
			busy <= addr_take;
			if (addr_take) begin
				req <= '{addr: haddr[etsr_pkg::ADDR_W-1:0], write: hwrite};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Readout of the current entry

	wire logic [W-1:0] status_word = head_valid ? status_of(head) : '0;

	logic [W-1:0] data_word;
	always_comb begin
		data_word = '0;
		case (wsel)
			etsr_pkg::WSEL_EXT:    data_word = ext_of(cur.cap);
			etsr_pkg::WSEL_NS_LO:  data_word = cur.cap.ns[15:0];
			etsr_pkg::WSEL_NS_HI:  data_word = {2'h0, cur.cap.ns[29:16]};
			etsr_pkg::WSEL_SEC_LO: data_word = cur.cap.sec[15:0];
			etsr_pkg::WSEL_SEC_HI: data_word = cur.cap.sec[31:16];
			default:               data_word = '0;
		endcase
	end

	// After the last word the walk restarts at the low nanoseconds
	logic [2:0] wsel_step;
	always_comb begin
		wsel_step = etsr_pkg::WSEL_NS_LO;
		case (wsel)
			etsr_pkg::WSEL_EXT:    wsel_step = etsr_pkg::WSEL_NS_LO;
			etsr_pkg::WSEL_NS_LO:  wsel_step = etsr_pkg::WSEL_NS_HI;
			etsr_pkg::WSEL_NS_HI:  wsel_step = etsr_pkg::WSEL_SEC_LO;
			etsr_pkg::WSEL_SEC_LO: wsel_step = etsr_pkg::WSEL_SEC_HI;
			default:               wsel_step = etsr_pkg::WSEL_NS_LO;
		endcase
	end

	wire logic [2:0] wsel_start = multi_of(head.cap.seen) ?
		etsr_pkg::WSEL_EXT : etsr_pkg::WSEL_NS_LO;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cur       <= '0;
			cur_valid <= 1'b0;
			wsel      <= etsr_pkg::WSEL_NS_LO;
		end else if (pop) begin
			cur       <= head;
			cur_valid <= 1'b1;
			wsel      <= etsr_pkg::etsr_wsel_t'(wsel_start);
		end else if (status_rd) begin
			cur       <= '0;
			cur_valid <= 1'b0;
			wsel      <= etsr_pkg::WSEL_NS_LO;
		end else if (data_rd) begin
			wsel <= etsr_pkg::etsr_wsel_t'(wsel_step);
		end
	end

	// Queue read side
	wire logic [AW:0] next_vis_fill =
		vis_fill + {{AW{1'b0}}, push_d1} - {{AW{1'b0}}, pop};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_ptr   <= '0;
			vis_fill <= '0;
		end else begin
			vis_fill <= next_vis_fill;
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupts

	logic [etsr_pkg::IRQ_W-1:0] irq_set;
	always_comb begin
		irq_set = '0;
		irq_set[etsr_pkg::IRQ_QUEUED]  = push;
		irq_set[etsr_pkg::IRQ_DROPPED] = drop;
	end

	wire logic [etsr_pkg::IRQ_W-1:0] irq_clr =
		(wr_act & sel_iclr) ? hwdata[etsr_pkg::IRQ_W-1:0] : '0;

	// A new event wins over a clear in the same cycle
	wire logic [etsr_pkg::IRQ_W-1:0] next_irq_status =
		(irq_status & ~irq_clr) | irq_set;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_status <= etsr_pkg::IRQ_STATUS_RESET;
			irq_enable <= etsr_pkg::IRQ_ENABLE_RESET;
		end else begin
			irq_status <= next_irq_status;
			if (wr_act && sel_ien) begin
				irq_enable <= hwdata[etsr_pkg::IRQ_W-1:0];
			end
		end
	end

	assign irq = |(irq_status & irq_enable);

	////////////////////////////////////////////////////////////////////////
	// Read data; the event data port ignores writes

	wire logic [31:0] rd_word =
		sel_status ? {16'h0000, status_word} :
		sel_data   ? {16'h0000, cur_valid ? data_word : 16'h0000} :
		sel_istat  ? {{(32-etsr_pkg::IRQ_W){1'b0}}, irq_status} :
		sel_ien    ? {{(32-etsr_pkg::IRQ_W){1'b0}}, irq_enable} :
		32'h0000_0000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_act) begin
			hrdata <= rd_word;
		end
	end
endmodule

// *** etsr_top_props.sv ***
// Assertions on the ports of the event timestamp readout
`timescale 1ns/1ps
module etsr_props #(
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic                    hclk,
	input wire logic                    hresetn,
	// Bus
	input wire logic                    hsel,
	input wire logic [31:0]             haddr,
	input wire logic [1:0]              htrans,
	input wire logic                    hwrite,
	input wire logic [2:0]              hsize,
	input wire logic [31:0]             hwdata,
	input wire logic                    hready,
	input wire logic                    hreadyout,
	input wire logic                    hresp,
	input wire logic [31:0]             hrdata,
	// Captures and interrupt
	input wire logic                    cap_valid,
	input wire etsr_pkg::etsr_capture_t cap_entry,
	input wire logic                    cap_ready,
	input wire logic                    irq
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic       pend, wq, empty;
	logic [9:0] aq;
	logic [2:0] pos;
	wire        take = hsel && htrans[1] && hready && hreadyout;
	wire        done = pend && hreadyout;
	wire        sd = done && !wq && aq == etsr_pkg::ADDR_EVENT_STATUS;
	wire        dd = done && !wq && aq == etsr_pkg::ADDR_EVENT_DATA;

	// Track the transfer in flight and the walk position
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend <= 1'b0;
			wq <= 1'b0;
			aq <= 10'h0;
		end else if (take) begin
			pend <= 1'b1;
			wq <= hwrite;
			aq <= haddr[9:0];
		end else if (done) begin
			pend <= 1'b0;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			empty <= 1'b1;
			pos <= 3'h1;
		end else if (sd) begin
			empty <= !hrdata[0];
			pos <= hrdata[1] ? 3'h0 : 3'h1;
		end else if (dd) begin
			pos <= (pos == 3'h4) ? 3'h1 : pos + 3'h1;
		end
	end
	////////////////////////////////////////
	sequence s_take;
		take;
	endsequence
	sequence s_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	property p_wait;
		s_take |=> s_wait;
	endproperty
	a_wait: assert property (p_wait) else $error("wait state wrong");
	property p_cause;
		!hreadyout |-> $past(take);
	endproperty
	a_cause: assert property (p_cause) else $error("stray wait");
	property p_hold;
		!$stable(hrdata) |-> done && !wq;
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_dtop;
		dd |-> hrdata[31:16] == 16'h0;
	endproperty
	a_dtop: assert property (p_dtop) else $error("data too wide");
	property p_szero;
		sd && !hrdata[0] |-> hrdata == 32'h0;
	endproperty
	a_szero: assert property (p_szero) else $error("status not zero");
	property p_smul;
		sd && hrdata[1] |-> hrdata[0];
	endproperty
	a_smul: assert property (p_smul) else $error("multi without entry");
	property p_nshi;
		dd && pos == 3'h2 |-> hrdata[15:14] == 2'h0;
	endproperty
	a_nshi: assert property (p_nshi) else $error("ns top bits set");
	property p_ext;
		dd && pos == 3'h0 |-> $countones(hrdata & 32'h5555) > 1;
	endproperty
	a_ext: assert property (p_ext) else $error("ext word unit count");
	property p_empty;
		dd && empty |-> hrdata == 32'h0;
	endproperty
	a_empty: assert property (p_empty) else $error("data without entry");
endmodule

bind etsr_top etsr_props #(.DEPTH(DEPTH)) u_props (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .cap_valid(cap_valid), .cap_entry(cap_entry),
	.cap_ready(cap_ready), .irq(irq)
);

// *** event_timestamp_readout_bench.sv ***
// Self-checking bench for the event timestamp readout
`timescale 1ns/1ps
module event_timestamp_readout_bench;
	localparam logic [9:0] a_st = etsr_pkg::ADDR_EVENT_STATUS;
	localparam logic [9:0] a_dt = etsr_pkg::ADDR_EVENT_DATA;
	localparam logic [9:0] a_is = etsr_pkg::ADDR_IRQ_STATUS;
	localparam logic [9:0] a_ie = etsr_pkg::ADDR_IRQ_ENABLE;
	localparam logic [9:0] a_ic = etsr_pkg::ADDR_IRQ_CLEAR;
	logic                    hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
	logic                    hwrite = 1'b0, cap_valid = 1'b0;
	logic                    hreadyout, hresp, cap_ready, irq;
	logic [1:0]              htrans = 2'h0;
	logic [31:0]             haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	etsr_pkg::etsr_capture_t cap_entry = '0, prev = '0, cur = '0;
	etsr_pkg::etsr_capture_t cq[$];
	logic [31:0]             eq[$];
	int                      fails = 0, checks_done = 0, miss = 0;

	etsr_top #(.DEPTH(2)) dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .cap_valid(cap_valid), .cap_entry(cap_entry),
		.cap_ready(cap_ready), .irq(irq)
	);
	initial begin
		forever #12.5 hclk = ~hclk;
	end
	////////////////////////////////////////
	task automatic summarize;
		$display("checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
			fails++;
		end
	endtask
	// Bounded wait for hready sampled high
	task automatic hw;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			fails++;
			summarize;
		end
	endtask
	task automatic bus(input logic [9:0] a, input logic w,
			input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {22'h0, a};
		hwrite <= w;
		hw;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		hw;
		rd = hrdata;
	endtask
	task automatic rdc(input logic [9:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk(rd, e);
	endtask
	task automatic push(input logic [29:0] ns, input logic [31:0] sec,
			input logic [7:0] s, input logic [7:0] u);
		etsr_pkg::etsr_capture_t c;
		int k;
		logic [1:0] ln;
		c = '{u, s, sec, ns};
		cap_entry <= c;
		cap_valid <= 1'b1;
		@(posedge hclk);
		if (cap_ready === 1'b1) begin
			k = 0;
			while (!s[k]) k++;
			ln = prev.sec[31:16] != sec[31:16] ? 2'h3 :
				prev.sec[15:0] != sec[15:0] ? 2'h2 :
				prev.ns[29:16] != ns[29:16] ? 2'h1 : 2'h0;
			eq.push_back({21'h0, 3'(miss), ln, u[k], 3'(k),
				$countones(s) > 1, 1'b1});
			miss = 0;
			cq.push_back(c);
			prev = c;
		end else if (miss < int'(etsr_pkg::MISSED_MAX)) begin
			miss++;
		end
	endtask
	task automatic sread;
		logic [31:0] e;
		e = 32'h0;
		if (eq.size() > 0) begin
			e = eq.pop_front();
			cur = cq.pop_front();
		end
		rdc(a_st, e);
	endtask
	function automatic logic [31:0] word(input etsr_pkg::etsr_capture_t c,
			input int i);
		logic [31:0] w;
		w = 32'h0;
		for (int n = 0; n < 8; n++) w[2*n +: 2] = {c.edge_up[n], c.seen[n]};
		case (i)
		1: w = {16'h0, c.ns[15:0]};
		2: w = {18'h0, c.ns[29:16]};
		3: w = {16'h0, c.sec[15:0]};
		4: w = {16'h0, c.sec[31:16]};
		default: ;
		endcase
		return w;
	endfunction
	task automatic walk(input int i, input int n);
		repeat (n) begin
			rdc(a_dt, word(cur, i));
			i = (i == 4) ? 1 : i + 1;
		end
	endtask
	task automatic settle;
		cap_valid <= 1'b0;
		repeat (2) @(posedge hclk);
	endtask
	////////////////////////////////////////
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk({31'h0, hresp}, 32'h0);
		sread;
		rdc(a_dt, 32'h0);
		bus(a_dt, 1'b1, 32'hffff);
		rdc(a_dt, 32'h0);
		rdc(a_ie, 32'h0);
		rdc(10'h100, 32'h0);
		rdc(a_ic, 32'h0);
		bus(a_ie, 1'b1, 32'h1);
		// Single capture: full walk with wrap, then interrupt clear
		push(30'h3bcd_1234, 32'h1234_5678, 8'h08, 8'h08);
		settle;
		chk({31'h0, irq}, 32'h1);
		rdc(a_is, 32'h1);
		sread;
		walk(1, 5);
		bus(a_ic, 1'b1, 32'h1);
		rdc(a_is, 32'h0);
		chk({31'h0, irq}, 32'h0);
		// Multi capture then single, both read only in part
		push(30'h0bce_0001, 32'h1234_5678, 8'h81, 8'h80);
		push(30'h0bce_0002, 32'h1234_5678, 8'h04, 8'h00);
		settle;
		sread;
		walk(0, 2);
		sread;
		walk(1, 1);
		sread;
		rdc(a_dt, 32'h0);
		// Overflow: third capture dropped, interrupt masked
		push(30'h0bce_0003, 32'h1234_0000, 8'h40, 8'h40);
		push(30'h0bce_0004, 32'h1234_0000, 8'h06, 8'h02);
		push(30'h0bce_0005, 32'h1234_0000, 8'h01, 8'h01);
		settle;
		chk({31'h0, cap_ready}, 32'h0);
		rdc(a_is, 32'h3);
		bus(a_ie, 1'b1, 32'h2);
		rdc(a_ie, 32'h2);
		chk({31'h0, irq}, 32'h1);
		bus(a_ic, 1'b1, 32'h2);
		rdc(a_is, 32'h1);
		chk({31'h0, irq}, 32'h0);
		sread;
		sread;
		walk(0, 5);
		// Next accepted capture carries the dropped count
		push(30'h0bce_0006, 32'h1234_0000, 8'h10, 8'h00);
		settle;
		sread;
		chk({31'h0, hresp}, 32'h0);
		sread;
		summarize;
	end
endmodule
